// >>> design/discovery_pkg.sv
package discovery_pkg;

	// protocol select codes
	localparam logic [1:0] PROTO_EXT  = 2'h0;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;

	// phase lengths in bits or serial clocks
	localparam logic [5:0] CMD_BITS        = 6'h08;
	localparam logic [5:0] ADDR_BITS       = 6'h18;
	localparam logic [5:0] DUMMY_EXT_DUAL  = 6'h08;
	localparam logic [5:0] DUMMY_QUAD      = 6'h0A;

	localparam int         TABLE_AW        = 11;
	localparam int         FIFO_WORDS      = 8;
	localparam int         BYTE_W          = 8;
	localparam logic [7:0] DEFAULT_OPCODE  = 8'h5A;
	localparam logic [7:0] ERASED_BYTE     = 8'hFF;

	// reset values of the synchroniser stages
	localparam logic [2:0] SCLK_SYNC_RST   = 3'h0;
	localparam logic [1:0] CS_SYNC_RST     = 2'h3;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_CMD    = 6'h02,
		ST_ADDR   = 6'h04,
		ST_DUMMY  = 6'h08,
		ST_DATA   = 6'h10,
		ST_IGNORE = 6'h20
	} state_t;

endpackage

// >>> design/byte_fifo_if.sv
`timescale 1ns/1ps
interface byte_fifo_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] wdata;
	logic             wvalid;
	logic             wready;
	logic [WIDTH-1:0] rdata;
	logic             rvalid;
	logic             rready;
	logic             flush;

	modport producer (output wdata, output wvalid, output flush,
		input wready);
	modport consumer (input rdata, input rvalid, output rready);
	modport buffer (input wdata, input wvalid, input flush,
		input rready, output wready, output rdata, output rvalid);
endinterface

// >>> design/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic     clk,
	input wire logic     rst,
	byte_fifo_if.buffer  port
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("byte_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} fifo_state_t;

	fifo_state_t r;
	fifo_state_t next_r;
	logic        push;
	logic        pop;

	assign port.wready = r.cnt != (AW + 1)'(DEPTH);
	assign port.rvalid = r.cnt != '0;
	assign port.rdata  = r.mem[r.rp];
	assign push        = port.wvalid & port.wready;
	assign pop         = port.rvalid & port.rready;

	always_comb begin
		next_r = r;
		if (port.flush) begin
			next_r.wp  = '0;
			next_r.rp  = '0;
			next_r.cnt = '0;
		end else begin
			if (push) begin
				next_r.mem[r.wp] = port.wdata;
				next_r.wp        = r.wp + 1'b1;
			end
			if (pop)
				next_r.rp = r.rp + 1'b1;
			if (push && !pop)
				next_r.cnt = r.cnt + 1'b1;
			else if (pop && !push)
				next_r.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end
endmodule

// >>> design/discovery_table_read.sv
// Notes on behaviour
// - chip select low, then command byte, then three address bytes.
// - extended and dual protocols insert eight dummy clocks before data.
// - quad protocol inserts ten dummy clocks before data.
// - data starts at received address and advances one byte each.
// - pointer wraps from the last of 2048 bytes to zero.
// - chip select high stops driving and abandons the transfer.
// - always continuous; no burst wrap length applies.
// - bytes 00h-03h signature 53h 46h 44h 50h; revision 00h, 01h.
// - 06h gives header count 00h, 07h gives FFh.
// - first parameter header fields at 08h through 0Fh.
// - locations 10h through 2Fh return FFh.
// - 30h erase size 01b, granularity 1, bits 3-4 zero, 7:5 ones.
// - 31h returns 20h, the 4KB erase opcode.
// - 32h reports fast read modes, address field 00b; 33h FFh.
// - 34h-37h give size in bits minus one, low byte first.
// - 38h/39h describe the 1-4-4 read.
// - 3Ah/3Bh describe the 1-1-4 read.
// - 3Ch/3Dh describe the 1-1-2 read.
// - 3Eh/3Fh describe the 1-2-2 read.
// - 40h read modes, 41h-45h FFh, 46h/47h 2-2-2, 48h-49h FFh.
// - 4Ah/4Bh describe the 4-4-4 read.
// - erase types at 4Ch-4Fh; 50h-53h return 00h.
// - each input bit is sampled on the serial clock rising edge.
`timescale 1ns/1ps
module discovery_table_read
	import discovery_pkg::*;
#(
	parameter logic [7:0] OPCODE     = DEFAULT_OPCODE,
	parameter int         FIFO_DEPTH = FIFO_WORDS
) (
	input  wire logic       REF_CLK,
	input  wire logic       SRST,
	input  wire logic       CHIP_SELECT_N,
	input  wire logic       SERIAL_CLK,
	input  wire logic [3:0] DATA_LINES_IN,
	output logic      [3:0] DATA_LINES_OUT,
	output logic      [3:0] DATA_LINES_OE,
	input  wire logic [1:0] PROTOCOL,
	output logic            BUSY
);

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("discovery_table_read: FIFO_DEPTH must be at least 2");
	end

	typedef struct packed {
		state_t                st;
		logic [2:0]            sclk_s;
		logic [1:0]            cs_s;
		logic [3:0]            din_s0;
		logic [3:0]            din_s1;
		logic [7:0]            sh_in;
		logic [23:0]           addr;
		logic [5:0]            cnt;
		logic [TABLE_AW-1:0]   ptr;
		logic [7:0]            sh_out;
		logic [3:0]            left;
		logic [3:0]            dout;
		logic [3:0]            doe;
	} core_t;

	core_t r;
	core_t next_r;

	byte_fifo_if #(.WIDTH(BYTE_W)) q ();

	byte_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk  (REF_CLK),
		.rst  (SRST),
		.port (q.buffer)
	);

	// lines carried per serial clock in the active protocol
	function automatic logic [2:0] lanes(input logic [1:0] p);
		unique case (p)
			PROTO_QUAD: return 3'h4;
			PROTO_DUAL: return 3'h2;
			default:    return 3'h1;
		endcase
	endfunction

	function automatic logic [23:0] shift_bits(input logic [23:0] v,
		input logic [3:0] d, input logic [1:0] p);
		unique case (p)
			PROTO_QUAD: return {v[19:0], d};
			PROTO_DUAL: return {v[21:0], d[1:0]};
			default:    return {v[22:0], d[0]};
		endcase
	endfunction

	// top bits of a byte placed on the output lines
	function automatic logic [3:0] place(input logic [7:0] b,
		input logic [1:0] p);
		unique case (p)
			PROTO_QUAD: return b[7:4];
			PROTO_DUAL: return {2'h0, b[7:6]};
			default:    return {2'h0, b[7], 1'b0};
		endcase
	endfunction

	function automatic logic [3:0] drive_mask(input logic [1:0] p);
		unique case (p)
			PROTO_QUAD: return 4'hF;
			PROTO_DUAL: return 4'h3;
			default:    return 4'h2;
		endcase
	endfunction

	// dummy clocks between address and data
	function automatic logic [5:0] dummy_clocks(input logic [1:0] p);
		unique case (p)
			PROTO_QUAD: return DUMMY_QUAD;
			default:    return DUMMY_EXT_DUAL;
		endcase
	endfunction

	// mode-bit count above dummy count, as in every fast read entry
	function automatic logic [7:0] read_mode_byte(
		input logic [2:0] mode_bits, input logic [4:0] dummies);
		return {mode_bits, dummies};
	endfunction

	function automatic logic [7:0] discovery_byte(
		input logic [TABLE_AW-1:0] a);
		unique case (a)
			11'h000: return 8'h53;
			11'h001: return 8'h46;
			11'h002: return 8'h44;
			11'h003: return 8'h50;
			11'h004: return 8'h00;
			11'h005: return 8'h01;
			11'h006: return 8'h00;
			11'h007: return 8'hFF;
			11'h008: return 8'h00;
			11'h009: return 8'h00;
			11'h00A: return 8'h01;
			11'h00B: return 8'h09;
			11'h00C: return 8'h30;
			11'h00D: return 8'h00;
			11'h00E: return 8'h00;
			11'h00F: return 8'hFF;
			11'h010: return ERASED_BYTE;
			11'h011: return ERASED_BYTE;
			11'h012: return ERASED_BYTE;
			11'h013: return ERASED_BYTE;
			11'h014: return ERASED_BYTE;
			11'h015: return ERASED_BYTE;
			11'h016: return ERASED_BYTE;
			11'h017: return ERASED_BYTE;
			11'h018: return ERASED_BYTE;
			11'h019: return ERASED_BYTE;
			11'h01A: return ERASED_BYTE;
			11'h01B: return ERASED_BYTE;
			11'h01C: return ERASED_BYTE;
			11'h01D: return ERASED_BYTE;
			11'h01E: return ERASED_BYTE;
			11'h01F: return ERASED_BYTE;
			11'h020: return ERASED_BYTE;
			11'h021: return ERASED_BYTE;
			11'h022: return ERASED_BYTE;
			11'h023: return ERASED_BYTE;
			11'h024: return ERASED_BYTE;
			11'h025: return ERASED_BYTE;
			11'h026: return ERASED_BYTE;
			11'h027: return ERASED_BYTE;
			11'h028: return ERASED_BYTE;
			11'h029: return ERASED_BYTE;
			11'h02A: return ERASED_BYTE;
			11'h02B: return ERASED_BYTE;
			11'h02C: return ERASED_BYTE;
			11'h02D: return ERASED_BYTE;
			11'h02E: return ERASED_BYTE;
			11'h02F: return ERASED_BYTE;
			11'h030: return 8'hE5;
			11'h031: return 8'h20;
			11'h032: return 8'hF1;
			11'h033: return 8'hFF;
			11'h034: return 8'hFF;
			11'h035: return 8'hFF;
			11'h036: return 8'hFF;
			11'h037: return 8'h03;
			11'h038: return read_mode_byte(3'h1, 5'h09);
			11'h039: return 8'hEB;
			11'h03A: return read_mode_byte(3'h1, 5'h07);
			11'h03B: return 8'h6B;
			11'h03C: return read_mode_byte(3'h0, 5'h08);
			11'h03D: return 8'h3B;
			11'h03E: return read_mode_byte(3'h1, 5'h07);
			11'h03F: return 8'hBB;
			11'h040: return 8'hFF;
			11'h041: return ERASED_BYTE;
			11'h042: return ERASED_BYTE;
			11'h043: return ERASED_BYTE;
			11'h044: return ERASED_BYTE;
			11'h045: return ERASED_BYTE;
			11'h046: return read_mode_byte(3'h1, 5'h07);
			11'h047: return 8'hBB;
			11'h048: return ERASED_BYTE;
			11'h049: return ERASED_BYTE;
			11'h04A: return read_mode_byte(3'h1, 5'h09);
			11'h04B: return 8'hEB;
			11'h04C: return 8'h0C;
			11'h04D: return 8'h20;
			11'h04E: return 8'h10;
			11'h04F: return 8'hD8;
			11'h050: return 8'h00;
			11'h051: return 8'h00;
			11'h052: return 8'h00;
			11'h053: return 8'h00;
			// everything above 53h
			default: return ERASED_BYTE;
		endcase
	endfunction

	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_high;
	logic [2:0] w;
	logic [5:0] cnt_lanes;
	logic [5:0] cnt_one;
	logic [5:0] dummy_len;
	logic [23:0] shifted;

	// edges seen on the second and third synchroniser stages
	assign sclk_rise = r.sclk_s[1] & ~r.sclk_s[2];
	assign sclk_fall = ~r.sclk_s[1] & r.sclk_s[2];
	assign cs_high   = r.cs_s[1];
	assign w         = lanes(PROTOCOL);
	assign cnt_lanes = r.cnt + {3'h0, w};
	assign cnt_one   = r.cnt + 6'h01;
	assign shifted   = shift_bits(r.addr, r.din_s1, PROTOCOL);
	assign dummy_len = dummy_clocks(PROTOCOL);

	// table bytes are queued ahead of the shifter from address capture on
	assign q.wvalid = (r.st == ST_DUMMY || r.st == ST_DATA) && !cs_high;
	assign q.wdata  = discovery_byte(r.ptr);
	assign q.flush  = cs_high;
	assign q.rready = (r.st == ST_DATA) && !cs_high && sclk_fall
		&& r.left == 4'h0;

	assign DATA_LINES_OUT = r.dout;
	assign DATA_LINES_OE  = r.doe;
	assign BUSY           = r.st != ST_IDLE;

	always_comb begin
		next_r        = r;
		next_r.sclk_s = {r.sclk_s[1:0], SERIAL_CLK};
		next_r.cs_s   = {r.cs_s[0], CHIP_SELECT_N};
		next_r.din_s0 = DATA_LINES_IN;
		next_r.din_s1 = r.din_s0;

		// continuous pointer; no burst wrap length is consulted
		if (q.wvalid && q.wready)
			next_r.ptr = r.ptr + 1'b1;

		if (cs_high) begin
			// deselect ends any phase at once
			next_r.st   = ST_IDLE;
			next_r.doe  = 4'h0;
			next_r.cnt  = 6'h00;
			next_r.left = 4'h0;
		end else begin
			unique case (r.st)
				ST_IDLE: begin
					next_r.st  = ST_CMD;
					next_r.cnt = 6'h00;
				end
				ST_CMD: begin
					if (sclk_rise) begin
						next_r.sh_in = 8'(shift_bits({16'h0, r.sh_in},
							r.din_s1, PROTOCOL));
						next_r.cnt   = cnt_lanes;
						if (cnt_lanes >= CMD_BITS) begin
							next_r.cnt = 6'h00;
							next_r.st  = (next_r.sh_in == OPCODE)
								? ST_ADDR : ST_IGNORE;
						end
					end
				end
				ST_ADDR: begin
					if (sclk_rise) begin
						next_r.addr = shifted;
						next_r.cnt  = cnt_lanes;
						if (cnt_lanes >= ADDR_BITS) begin
							next_r.cnt = 6'h00;
							next_r.ptr = shifted[TABLE_AW-1:0];
							next_r.st  = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (sclk_rise) begin
						next_r.cnt = cnt_one;
						if (cnt_one >= dummy_len) begin
							next_r.st   = ST_DATA;
							next_r.left = 4'h0;
						end
					end
				end
				ST_DATA: begin
					// shift out on falling edges, MSB first
					if (sclk_fall) begin
						next_r.doe = drive_mask(PROTOCOL);
						if (r.left == 4'h0) begin
							if (q.rvalid) begin
								next_r.dout   = place(q.rdata, PROTOCOL);
								next_r.sh_out = q.rdata << w;
								next_r.left   = 4'h8 - {1'b0, w};
							end
						end else begin
							next_r.dout   = place(r.sh_out, PROTOCOL);
							next_r.sh_out = r.sh_out << w;
							next_r.left   = r.left - {1'b0, w};
						end
					end
				end
				ST_IGNORE: begin
					next_r.doe = 4'h0;
				end
				default: begin
					next_r.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			r        <= '0;
			r.st     <= ST_IDLE;
			r.sclk_s <= SCLK_SYNC_RST;
			r.cs_s   <= CS_SYNC_RST;
		end else begin
			r <= next_r;
		end
	end
endmodule

// >>> sim/discovery_table_read_sva.sv
`timescale 1ns/1ps
module discovery_table_read_sva
	import discovery_pkg::*;
(
	input wire logic       REF_CLK,
	input wire logic       SRST,
	input wire logic       CHIP_SELECT_N,
	input wire logic       SERIAL_CLK,
	input wire logic [3:0] DATA_LINES_IN,
	input wire logic [3:0] DATA_LINES_OUT,
	input wire logic [3:0] DATA_LINES_OE,
	input wire logic [1:0] PROTOCOL,
	input wire logic       BUSY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	logic       sclk_q;
	logic [7:0] rises;
	logic [7:0] need;
	// serial clock rises seen since chip select fell
	always_ff @(posedge REF_CLK) begin
		sclk_q <= SERIAL_CLK;
		if (SRST || CHIP_SELECT_N)
			rises <= 8'h00;
		else if (SERIAL_CLK && !sclk_q)
			rises <= rises + 8'h01;
	end
	assign need = PROTOCOL == PROTO_QUAD ? 8'h12 :
		PROTOCOL == PROTO_DUAL ? 8'h18 : 8'h28;
	property p_busy_rise;
		$fell(CHIP_SELECT_N) |-> ##[1:6] BUSY;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy late");
	property p_dummy;
		$rose(|DATA_LINES_OE) |-> rises == need;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy count");
	property p_ext_lane;
		PROTOCOL == PROTO_EXT && DATA_LINES_OE != 4'h0 |-> DATA_LINES_OE == 4'h2;
	endproperty
	a_ext_lane: assert property (p_ext_lane) else $error("ext lanes");
	property p_dual_lane;
		PROTOCOL == PROTO_DUAL && DATA_LINES_OE != 4'h0 |-> DATA_LINES_OE == 4'h3;
	endproperty
	a_dual_lane: assert property (p_dual_lane) else $error("dual lanes");
	property p_quad_lane;
		PROTOCOL == PROTO_QUAD && DATA_LINES_OE != 4'h0 |-> DATA_LINES_OE == 4'hF;
	endproperty
	a_quad_lane: assert property (p_quad_lane) else $error("quad lanes");
	property p_oe_in_frame;
		$rose(|DATA_LINES_OE) |-> BUSY && !CHIP_SELECT_N;
	endproperty
	a_oe_in_frame: assert property (p_oe_in_frame) else $error("oe out of frame");
	property p_out_hold;
		(SERIAL_CLK && !CHIP_SELECT_N)[*6] |->
			$stable(DATA_LINES_OUT) && $stable(DATA_LINES_OE);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output moved");
	property p_abort;
		$rose(CHIP_SELECT_N) |-> ##[1:6] (DATA_LINES_OE == 4'h0 && !BUSY);
	endproperty
	a_abort: assert property (p_abort) else $error("no release");
	c_ext: cover property (PROTOCOL == PROTO_EXT && DATA_LINES_OE == 4'h2);
	c_quad: cover property (DATA_LINES_OE == 4'hF);
	c_abort: cover property ($rose(CHIP_SELECT_N) && DATA_LINES_OE != 4'h0);
endmodule

bind discovery_table_read discovery_table_read_sva discovery_table_read_sva_inst (
	.REF_CLK(REF_CLK), .SRST(SRST), .CHIP_SELECT_N(CHIP_SELECT_N),
	.SERIAL_CLK(SERIAL_CLK), .DATA_LINES_IN(DATA_LINES_IN),
	.DATA_LINES_OUT(DATA_LINES_OUT), .DATA_LINES_OE(DATA_LINES_OE),
	.PROTOCOL(PROTOCOL), .BUSY(BUSY)
);

// >>> sim/host_model.sv
`timescale 1ns/1ps
module host_model
	import discovery_pkg::*;
(
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] drv,
	input  wire logic [3:0] lines,
	input  wire logic [1:0] proto
);
	localparam time HALF = 80ns;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv  = 4'h0;
	end
	function automatic int lanes();
		return proto == PROTO_DUAL ? 2 : proto == PROTO_QUAD ? 4 : 1;
	endfunction
	// undriven lanes toggle so stale values never pass
	task automatic shift_out(input logic [7:0] b);
		repeat (8 / lanes()) begin
			case (lanes())
				1: drv = {~drv[3:1], b[7]};
				2: drv = {~drv[3:2], b[7:6]};
				default: drv = b[7:4];
			endcase
			b = b << lanes();
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
	endtask
	task automatic xfer(input logic [7:0] op, input logic [23:0] a,
			input int n, input int extra, output logic [7:0] got [$]);
		logic [7:0] b;
		got = {};
		cs_n = 1'b0;
		shift_out(op);
		for (int k = 2; k >= 0; k--)
			shift_out(a[k*8 +: 8]);
		repeat (proto == PROTO_QUAD ? 10 : 8) begin
			drv = ~drv;
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
		for (int i = 0; i < n * 8 / lanes() + extra; i++) begin
			drv = ~drv;
			#HALF sclk = 1'b1;
			b = lanes() == 1 ? {b[6:0], lines[1]} :
				lanes() == 2 ? {b[5:0], lines[1:0]} : {b[3:0], lines};
			if ((i + 1) % (8 / lanes()) == 0)
				got.push_back(b);
			#HALF sclk = 1'b0;
		end
		cs_n = 1'b1;
		#(2 * HALF);
	endtask
endmodule

// >>> sim/discovery_table_read_test.sv
`timescale 1ns/1ps
module test_discovery_table_read import discovery_pkg::*;;
	typedef struct {
		logic [1:0]  proto;
		logic [23:0] addr;
		int          n;
	} row_t;
	localparam logic [7:0] HDR [16] = '{8'h53, 8'h46, 8'h44, 8'h50,
		8'h00, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09,
		8'h30, 8'h00, 8'h00, 8'hFF};
	localparam logic [7:0] PRM [36] = '{
		8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03,
		8'h29, 8'hEB, 8'h27, 8'h6B, 8'h08, 8'h3B, 8'h27, 8'hBB,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h27, 8'hBB,
		8'hFF, 8'hFF, 8'h29, 8'hEB, 8'h0C, 8'h20, 8'h10, 8'hD8,
		8'h00, 8'h00, 8'h00, 8'h00};
	row_t rows [5] = '{'{PROTO_EXT, 24'h000000, 86},
		'{PROTO_DUAL, 24'h000030, 10}, '{PROTO_QUAD, 24'h000038, 20},
		'{2'h3, 24'h00004C, 8}, '{PROTO_QUAD, 24'hABC7FE, 4}};
	logic       ref_clk, srst, cs_n, sclk, busy, oe_hit;
	logic [3:0] drv, din, dout, oe;
	logic [1:0] proto;
	logic [7:0] got [$];
	int         num_errors, total_checks, cycles;
	discovery_table_read discovery_table_read_inst (
		.REF_CLK(ref_clk), .SRST(srst), .CHIP_SELECT_N(cs_n),
		.SERIAL_CLK(sclk), .DATA_LINES_IN(din), .DATA_LINES_OUT(dout),
		.DATA_LINES_OE(oe), .PROTOCOL(proto), .BUSY(busy));
	host_model host_model_inst (.cs_n(cs_n), .sclk(sclk), .drv(drv),
		.lines(din), .proto(proto));
	assign din = (oe & dout) | (~oe & drv);
	function automatic logic [7:0] tbl(input logic [10:0] a);
		if (a < 11'h010)
			return HDR[a];
		if (a < 11'h030 || a > 11'h053)
			return 8'hFF;
		return PRM[a - 11'h030];
	endfunction
	task automatic check(input string what, input logic [7:0] exp, act);
		total_checks++;
		if (exp !== act) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (oe != 4'h0)
			oe_hit <= 1'b1;
		if (cycles == 40000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		srst = 1'b1;
		proto = PROTO_EXT;
		oe_hit = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1 srst = 1'b0;
		check("oe at reset", 8'h00, {4'h0, oe});
		check("out at reset", 8'h00, {4'h0, dout});
		check("busy at reset", 8'h00, {7'h00, busy});
		foreach (rows[r]) begin
			proto = rows[r].proto;
			host_model_inst.xfer(DEFAULT_OPCODE, rows[r].addr, rows[r].n, 0,
				got);
			for (int i = 0; i < rows[r].n; i++)
				check("byte", tbl(rows[r].addr[10:0] + 11'(i)), got[i]);
		end
		proto = PROTO_DUAL;
		host_model_inst.xfer(DEFAULT_OPCODE, 24'h000005, 1, 2, got);
		check("byte before abort", tbl(11'h005), got[0]);
		check("oe after abort", {4'h0, oe}, 8'h00);
		check("busy after abort", {7'h00, busy}, 8'h00);
		proto = PROTO_EXT;
		host_model_inst.xfer(DEFAULT_OPCODE, 24'h0007FF, 2, 0, got);
		check("last byte", 8'hFF, got[0]);
		check("wrapped byte", 8'h53, got[1]);
		oe_hit = 1'b0;
		host_model_inst.xfer(8'hA5, 24'h000000, 2, 0, got);
		check("oe on other opcode", {7'h00, oe_hit}, 8'h00);
		report_and_stop();
	end
endmodule
